/* verilog/dtr_pkg.sv */
// shared constants and types for the D-PHY timing override register bank
package dtr_pkg;

    // =====================================================================
    // types
    typedef logic [6:0]       dtr_field_t;
    typedef dtr_field_t [5:0] dtr_set_t;

    // slot 0 is the least significant field
    typedef struct packed {
        dtr_field_t hs_exit;
        dtr_field_t hs_trail;
        dtr_field_t hs_zero;
        dtr_field_t hs_prepare;
        dtr_field_t clk_post;
        dtr_field_t clk_trail;
    } dtr_timing_t;

    typedef enum logic [2:0] {
        RATE_400  = 3'h0,
        RATE_800  = 3'h1,
        RATE_1200 = 3'h2,
        RATE_1500 = 3'h3,
        RATE_1600 = 3'h4
    } dtr_rate_t;

    typedef enum logic [1:0] {
        PH_DECODE = 2'h0,
        PH_FETCH  = 2'h1,
        PH_ANSWER = 2'h2
    } dtr_phase_t;

    // =====================================================================
    // bus and register map (indices; byte address is four times the index)
    localparam int                AVS_AW     = 10;
    localparam int                AVS_DW     = 32;
    localparam int                NUM_SLOTS  = 6;
    localparam logic [2:0]        SLOT_NONE  = 3'h7;
    localparam logic [5:0][7:0]   TIMING_IDX = {8'h47, 8'h46, 8'h45, 8'h44, 8'h43, 8'h42};
    localparam logic [7:0]        IDX_RATE   = 8'h50;
    localparam logic [7:0]        IDX_STATUS = 8'h51;

    // =====================================================================
    // field positions
    localparam int OVR_BIT       = 7;
    localparam int STAT_RATE_LSB = 0;
    localparam int STAT_OVR_LSB  = 8;

    // =====================================================================
    // computed timing per lane rate, fields ordered exit..clk_trail
    localparam dtr_set_t RATE_TABLE [5] = '{
        {7'h06, 7'h04, 7'h06, 7'h03, 7'h09, 7'h06},
        {7'h0B, 7'h08, 7'h0C, 7'h06, 7'h0A, 7'h0B},
        {7'h10, 7'h0B, 7'h12, 7'h08, 7'h0C, 7'h10},
        {7'h14, 7'h0E, 7'h16, 7'h0A, 7'h0D, 7'h14},
        {7'h15, 7'h0F, 7'h18, 7'h0B, 7'h0E, 7'h15}
    };
    localparam dtr_rate_t RATE_RESET = RATE_800;
    localparam dtr_rate_t RATE_MAX   = RATE_1600;
    localparam dtr_set_t  RESET_SET  = RATE_TABLE[1];

endpackage : dtr_pkg

/* verilog/dtr_rate_rom.sv */
// lookup of computed D-PHY timing values for the selected lane rate
`timescale 1ns/10ps
`default_nettype none

module dtr_rate_rom
    import dtr_pkg::*;
(
    input  wire logic      i_clk,
    input  wire logic      i_rst,
    input  wire dtr_rate_t i_rate,
    output dtr_set_t       o_set,
    output dtr_rate_t      o_rate
);

    // =====================================================================
    // registered read; the reset row is the 800 Mbps row
    always_ff @(posedge i_clk) begin
        if (i_rst) begin
            o_set  <= RESET_SET;
            o_rate <= RATE_RESET;
        end else begin
            o_set  <= RATE_TABLE[i_rate];
            o_rate <= i_rate;
        end
    end

endmodule // dtr_rate_rom

`default_nettype wire

/* verilog/dtr_regs.sv */
// D-PHY transmit timing override register bank on an Avalon-MM slave
//
// Notes on behaviour
// - Register 0x42 bit 7 picks computed or written clock-lane trail time from bits 6:0, field resets to 0xB.
// - Register 0x43 bit 7 picks computed or written clock-lane post time from bits 6:0, field resets to 0xA.
// - Register 0x44 bit 7 picks computed or written data-lane prepare time, register resets to 0x06.
// - Register 0x45 bit 7 picks computed or written data-lane zero time, register resets to 0x0C.
// - Register 0x46 bit 7 picks computed or written data-lane trail time, field resets to 0x8.
// - Register 0x47 bit 7 picks computed or written data-lane exit time, field resets to 0xB.
// - With the select bit clear the value field drops writes and reads back the live computed value.
// - With the select bit set the value field stores writes, reads them back and drives the timing.
// - Reset values are the 800 Mbps figures and computed values follow the chosen lane rate.
//
// The Avalon-MM register port was chosen for this implementation.
`timescale 1ns/10ps
`default_nettype none

module dtr_regs
    import dtr_pkg::*;
(
    input  wire logic              i_clk,
    input  wire logic              i_rst,
    input  wire logic [AVS_AW-1:0] i_avs_address,
    input  wire logic              i_avs_read,
    input  wire logic              i_avs_write,
    input  wire logic [AVS_DW-1:0] i_avs_writedata,
    input  wire logic [3:0]        i_avs_byteenable,
    output logic [AVS_DW-1:0]      o_avs_readdata,
    output logic                   o_avs_waitrequest,
    output dtr_timing_t            o_timing,
    output dtr_rate_t              o_rate
);

    // =====================================================================
    // decode helpers
    function automatic logic hits(input logic [AVS_AW-1:0] a, input logic [7:0] idx);
        return (a[1:0] == 2'h0) && (a[AVS_AW-1:2] == idx);
    endfunction

    function automatic logic [2:0] slot_of(input logic [AVS_AW-1:0] a);
        logic [2:0] s;
        s = SLOT_NONE;
        for (int k = 0; k < NUM_SLOTS; k++) begin
            if (hits(a, TIMING_IDX[k])) begin
                s = 3'(k);
            end
        end
        return s;
    endfunction

    // =====================================================================
    // declarations
    dtr_phase_t       phase;
    dtr_phase_t       next_phase;
    logic             req;
    logic             wr_acc;
    logic [2:0]       slot;
    logic [5:0]       ovr_mask;
    dtr_set_t         stored;
    dtr_set_t         eff;
    dtr_set_t         rom_set;
    dtr_rate_t        rate;
    dtr_rate_t        rate_live;
    logic [AVS_DW-1:0] next_readdata;

    assign req    = i_avs_read | i_avs_write;
    assign slot   = slot_of(i_avs_address);
    assign wr_acc = i_avs_write && (phase == PH_ANSWER);

    // =====================================================================
    // bus handshake: decode, fetch, answer; the extra fetch cycle lets the
    // rate lookup settle after a rate write before any read samples it
    always_comb begin
        case (phase)
            PH_DECODE: next_phase = req ? PH_FETCH : PH_DECODE;
            PH_FETCH:  next_phase = req ? PH_ANSWER : PH_DECODE;
            PH_ANSWER: next_phase = PH_DECODE;
            default:   next_phase = PH_DECODE;
        endcase
    end

    always_ff @(posedge i_clk) begin
        if (i_rst) begin
            phase <= PH_DECODE;
        end else begin
            phase <= next_phase;
        end
    end

    assign o_avs_waitrequest = req && (phase != PH_ANSWER);

    // =====================================================================
    // rate select, illegal codes dropped
    always_ff @(posedge i_clk) begin
        if (i_rst) begin
            rate <= RATE_RESET;
        end else if (wr_acc && i_avs_byteenable[0] && hits(i_avs_address, IDX_RATE)
                     && (i_avs_writedata[2:0] <= RATE_MAX)) begin
            rate <= dtr_rate_t'(i_avs_writedata[2:0]);
        end
    end

    // computed values refresh one cycle after any rate change
    dtr_rate_rom u_rom (
        .i_clk  (i_clk),
        .i_rst  (i_rst),
        .i_rate (rate),
        .o_set  (rom_set),
        .o_rate (rate_live)
    );

    // =====================================================================
    // six override slots, 0x42 through 0x47
    for (genvar g = 0; g < NUM_SLOTS; g++) begin : g_slot
        logic       sel;
        dtr_field_t val;

        // select bit and value share one write; a value only lands when the
        // same write sets the select bit, otherwise it is dropped
        always_ff @(posedge i_clk) begin
            if (i_rst) begin
                sel <= 1'b0;
                val <= RESET_SET[g];
            end else if (wr_acc && i_avs_byteenable[0] && (slot == 3'(g))) begin
                sel <= i_avs_writedata[OVR_BIT];
                if (i_avs_writedata[OVR_BIT]) begin
                    val <= i_avs_writedata[6:0];
                end
            end
        end

        assign ovr_mask[g] = sel;
        assign stored[g]   = val;
        assign eff[g]      = sel ? val : rom_set[g];
    end

    assign o_timing = dtr_timing_t'(eff);
    assign o_rate   = rate_live;

    // =====================================================================
    // read path, captured in the fetch cycle and held through the answer
    always_comb begin
        next_readdata = '0;
        if (slot != SLOT_NONE) begin
            next_readdata[7:0] = {ovr_mask[slot], eff[slot]};
        end else if (hits(i_avs_address, IDX_RATE)) begin
            next_readdata[2:0] = rate;
        end else if (hits(i_avs_address, IDX_STATUS)) begin
            next_readdata[STAT_RATE_LSB +: 3] = rate_live;
            next_readdata[STAT_OVR_LSB +: 6]  = ovr_mask;
        end
    end

    always_ff @(posedge i_clk) begin
        if (i_rst) begin
            o_avs_readdata <= '0;
        end else if (i_avs_read && (phase == PH_FETCH)) begin
            o_avs_readdata <= next_readdata;
        end
    end

    // =====================================================================
    // checks
    default clocking cb @(posedge i_clk);
    endclocking
    default disable iff (i_rst);

    a_wait_two_cycles: assert property (
        (req && phase == PH_DECODE) |-> o_avs_waitrequest ##1 (!req || o_avs_waitrequest)
            ##1 (!req || !o_avs_waitrequest)
    ) else $error("answer not on third cycle of request");

    a_reset_values: assert property (disable iff (1'b0)
        ($past(i_rst) && !i_rst) |-> (o_timing == dtr_timing_t'(RESET_SET)) && (ovr_mask == 6'h00)
    ) else $error("timing set wrong after reset");

    a_auto_follows_rate: assert property (
        ($stable(rate) && ovr_mask == 6'h00) [*2] |-> (o_timing == dtr_timing_t'(RATE_TABLE[rate]))
    ) else $error("computed timing does not follow rate");

    a_override_stores: assert property (
        (wr_acc && i_avs_byteenable[0] && slot != SLOT_NONE && i_avs_writedata[OVR_BIT])
            |=> (eff[$past(slot)] == $past(i_avs_writedata[6:0])) && ovr_mask[$past(slot)]
    ) else $error("override value not applied");

    a_auto_write_drop: assert property (
        (wr_acc && i_avs_byteenable[0] && slot != SLOT_NONE && !i_avs_writedata[OVR_BIT])
            |=> !ovr_mask[$past(slot)] && $stable(stored[$past(slot)])
    ) else $error("value field took a write with select clear");

    a_read_reflects: assert property (
        (i_avs_read && !o_avs_waitrequest && slot != SLOT_NONE)
            |-> (o_avs_readdata == {24'h000000, ovr_mask[slot], eff[slot]})
    ) else $error("timing register read mismatch");

    a_unmapped_zero: assert property (
        (i_avs_read && !o_avs_waitrequest && slot == SLOT_NONE
            && !hits(i_avs_address, IDX_RATE) && !hits(i_avs_address, IDX_STATUS))
            |-> (o_avs_readdata == 32'h00000000)
    ) else $error("unmapped read not zero");

    a_rate_illegal: assert property (
        (wr_acc && hits(i_avs_address, IDX_RATE) && i_avs_writedata[2:0] > RATE_MAX) |=> $stable(rate)
    ) else $error("illegal rate code accepted");

    a_rom_latency: assert property (
        $changed(rate) |=> (rate_live == $past(rate)) ##1 (rate_live == $past(rate, 2))
    ) else $error("rate lookup latency wrong");

    c_override_write: cover property (
        wr_acc && slot != SLOT_NONE && i_avs_writedata[OVR_BIT]
    );
    c_rate_change: cover property (
        $changed(rate) ##2 (ovr_mask == 6'h00)
    );
    c_auto_read: cover property (
        i_avs_read && !o_avs_waitrequest && slot != SLOT_NONE && !ovr_mask[slot]
    );
    c_unmapped_read: cover property (
        i_avs_read && !o_avs_waitrequest && slot == SLOT_NONE
    );

endmodule // dtr_regs

`default_nettype wire

/* verif/dtr_csi_rx_model.sv */
// receiver-side model that takes up the effective D-PHY timing each cycle
`timescale 1ns/10ps
`default_nettype none

module dtr_csi_rx_model
    import dtr_pkg::*;
(
    input  wire logic        i_clk,
    input  wire dtr_timing_t i_timing,
    output logic [41:0]      o_seen
);
    // =====================================================================
    // capture
    // the receiver only ever sees the levels at a clock edge
    always_ff @(posedge i_clk) begin
        o_seen <= i_timing;
    end
endmodule // dtr_csi_rx_model

`default_nettype wire

/* verif/tb_top.sv */
// self-checking testbench for the D-PHY timing override register bank
`timescale 1ns/10ps
`default_nettype none

module tb_top
    import dtr_pkg::*;
;
    // =====================================================================
    // signals and model state
    logic              i_clk;
    logic              i_rst;
    logic [AVS_AW-1:0] avs_address;
    logic              avs_read;
    logic              avs_write;
    logic [AVS_DW-1:0] avs_writedata;
    logic [AVS_DW-1:0] avs_readdata;
    logic [3:0]        avs_byteenable;
    logic              avs_waitrequest;
    dtr_timing_t       timing;
    dtr_rate_t         rate_out;
    logic [41:0]       seen;
    logic [31:0]       q;
    logic [31:0]       d;
    logic [6:0]        st [6];
    bit                ov [6];
    bit                be0;
    int                n_mismatch;
    int                check_count;
    int                seed;
    int                rate;
    int                k;
    localparam logic [7:0] RST_VAL [6] = '{8'h0B, 8'h0A, 8'h06, 8'h0C, 8'h08, 8'h0B};

    dtr_regs dtr_regs_inst (
        .i_clk(i_clk), .i_rst(i_rst), .i_avs_address(avs_address), .i_avs_read(avs_read),
        .i_avs_write(avs_write), .i_avs_writedata(avs_writedata), .i_avs_byteenable(avs_byteenable),
        .o_avs_readdata(avs_readdata), .o_avs_waitrequest(avs_waitrequest), .o_timing(timing),
        .o_rate(rate_out));
    dtr_csi_rx_model dtr_csi_rx_model_inst (.i_clk(i_clk), .i_timing(timing), .o_seen(seen));

    initial begin
        i_clk = 1'b0;
        forever #20 i_clk = ~i_clk;
    end

    // =====================================================================
    // helpers
    function automatic logic [9:0] addr(input int i);
        return 10'(264 + 4 * i);
    endfunction

    function automatic logic [31:0] exp_rd(input int i);
        return {24'h0, ov[i], ov[i] ? st[i] : RATE_TABLE[rate][i]};
    endfunction

    function automatic logic [41:0] exp_t();
        logic [31:0] v;
        for (int i = 0; i < 6; i++) begin
            v = exp_rd(i);
            exp_t[7*i +: 7] = v[6:0];
        end
    endfunction

    task automatic print_verdict();
        $display("checks %0d mismatches %0d", check_count, n_mismatch);
        if (n_mismatch == 0 && check_count > 0) $display("[ PASS ]");
        else $display("[ FAIL ]");
        $finish;
    endtask

    task automatic chk(input logic [63:0] got, input logic [63:0] exp);
        check_count++;
        if (got !== exp) begin
            n_mismatch++;
            $display("ERROR t=%0t got %0h expected %0h", $time, got, exp);
        end
    endtask

    // one Avalon transfer; request held until waitrequest is sampled low at a rising edge,
    // read data taken and request released at that same edge
    task automatic bus(input bit w, input logic [9:0] a, input logic [31:0] wd, output logic [31:0] rd);
        int n;
        @(posedge i_clk);
        avs_write <= w;
        avs_read <= !w;
        avs_address <= a;
        avs_writedata <= wd;
        for (n = 0; n < 50; n++) begin
            @(posedge i_clk);
            if (avs_waitrequest === 1'b0) break;
        end
        if (n == 50) begin
            n_mismatch++;
            print_verdict();
        end
        rd = avs_readdata;
        avs_write <= 1'b0;
        avs_read <= 1'b0;
    endtask

    task automatic check_all();
        logic [31:0] sv;
        sv = 32'(rate);
        for (int i = 0; i < 6; i++) begin
            bus(0, addr(i), 32'h0, q);
            chk(q, exp_rd(i));
            sv[8 + i] = ov[i];
        end
        bus(0, 10'h140, 32'h0, q);
        chk(q, 32'(rate));
        bus(0, 10'h144, 32'h0, q);
        chk(q, sv);
        chk(64'(rate_out), 64'(rate));
        chk(seen, exp_t());
    endtask

    // =====================================================================
    // main sequence
    initial begin
        i_rst = 1'b1;
        avs_address = '0;
        avs_read = 1'b0;
        avs_write = 1'b0;
        avs_writedata = '0;
        avs_byteenable = 4'hF;
        n_mismatch = 0;
        check_count = 0;
        seed = 18826;
        rate = 1;
        for (int i = 0; i < 6; i++) ov[i] = 1'b0;
        repeat (5) @(posedge i_clk);
        i_rst <= 1'b0;
        for (int i = 0; i < 6; i++) begin
            bus(0, addr(i), 32'h0, q);
            chk(q, {24'h0, RST_VAL[i]});
        end
        // overrides survive a rate change, computed values do not
        for (int i = 0; i < 6; i++) begin
            bus(1, addr(i), 32'h80 | (i + 32), q);
            ov[i] = 1'b1;
            st[i] = 7'(i + 32);
        end
        bus(1, 10'h140, 32'h3, q);
        rate = 3;
        check_all();
        for (int i = 0; i < 6; i++) begin
            bus(1, addr(i), 32'h55, q);
            ov[i] = 1'b0;
        end
        check_all();
        // unmapped and misaligned places read zero, a misaligned write is not taken
        bus(1, 10'h109, 32'hFF, q);
        bus(0, 10'h109, 32'h0, q);
        chk(q, 32'h0);
        bus(0, 10'h120, 32'h0, q);
        chk(q, 32'h0);
        // random traffic; codes above the top rate and cleared byte lanes are dropped
        for (int it = 0; it < 80; it++) begin
            k = ($random(seed) & 32'h7FFF) % 7;
            d = $random(seed) & 32'hFF;
            be0 = ($random(seed) & 3) != 0;
            avs_byteenable <= be0 ? 4'hF : 4'hE;
            if (k == 6) begin
                bus(1, 10'h140, d & 32'h7, q);
                if (be0 && (d & 7) <= 4) rate = d & 7;
            end else begin
                bus(1, addr(k), d, q);
                if (be0) begin
                    ov[k] = d[7];
                    if (d[7]) st[k] = d[6:0];
                end
                bus(0, addr(k), 32'h0, q);
                chk(q, exp_rd(k));
            end
            if (it % 10 == 9) check_all();
        end
        avs_byteenable <= 4'hF;
        check_all();
        print_verdict();
    end
endmodule // tb_top

`default_nettype wire
